// [src/lecr_regs.sv]
// regulator-three enable control: config and voltage registers, enable, discharge and mode latch
// assumes a plain register port synchronous to clk_i and one strobe at a time
`timescale 1ns/1ps
`default_nettype none
`include "lecr_defs.svh"

// Operation
// - slot code read-only; 000 off, 001 on.
// - 010/011/100 enable at 0/25/50 percent.
// - 111 hands control to software after 100%.
// - selector ignored unless slot code is 111.
// - selector 00 disables, 01 enables.
// - selector 10 follows first input only.
// - selector 11 follows second input only.
// - discharge bit set: discharge when enable low.
// - mode bit set runs load switch.
// - mode latched, applied only while disabled.
module lecr_regs
	import lecr_pkg::*;
#(
	parameter int BOOT_DELAY_CYCLES = `LECR_BOOT_DELAY_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	// system state
	input wire logic supply_present_i,
	input wire logic power_off_state_i,
	input wire logic [2:0] seq_strap_i,
	// multipurpose inputs
	input wire logic multipurpose_input_first_i,
	input wire logic multipurpose_input_second_i,
	// regulator controls
	output logic ldo_enable_o,
	output logic load_switch_o,
	output logic discharge_o,
	output logic [4:0] output_voltage_code_o
);
	lecr_seq_t sequence_slot_code;
	logic seq_loaded;
	lecr_sel_t software_enable_select;
	logic active_discharge_on_disable;
	logic load_switch_select;
	logic next_enable;
	logic next_discharge;
	logic [7:0] next_rd_data;
	logic phase_0;
	logic phase_25;
	logic phase_50;
	logic phase_100;
	logic cfg_wr;
	logic volt_wr;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	assign cfg_wr = wr_en_i && hit(addr_i, `LECR_CFG_ADDR);
	assign volt_wr = wr_en_i && hit(addr_i, `LECR_VOLT_ADDR);

	lecr_boot_timer #(
		.DELAY_CYCLES(BOOT_DELAY_CYCLES)
	) u_boot_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.supply_present_i(supply_present_i),
		.phase_0_o(phase_0),
		.phase_25_o(phase_25),
		.phase_50_o(phase_50),
		.phase_100_o(phase_100)
	);

	// factory slot caught once after reset release, never written by software
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sequence_slot_code <= lecr_seq_t'(`LECR_SEQ_RST);
			seq_loaded <= 1'b0;
		end else if (!seq_loaded) begin
			sequence_slot_code <= lecr_seq_t'(seq_strap_i);
			seq_loaded <= 1'b1;
		end
	end

	// writable config fields
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			software_enable_select <= lecr_sel_t'(`LECR_SEL_RST);
			active_discharge_on_disable <= `LECR_DSC_RST;
			load_switch_select <= `LECR_MODE_RST;
		end else if (cfg_wr) begin
			software_enable_select <= lecr_sel_t'(wr_data_i[`LECR_SEL_MSB:`LECR_SEL_LSB]);
			active_discharge_on_disable <= wr_data_i[`LECR_DSC_BIT];
			load_switch_select <= wr_data_i[`LECR_MODE_BIT];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			output_voltage_code_o <= `LECR_VOLT_RST;
		end else if (volt_wr) begin
			output_voltage_code_o <= wr_data_i[`LECR_VOLT_MSB:0];
		end
	end

	// effective enable from slot code, boot phase and selector
	always_comb begin
		next_enable = 1'b0;
		if (supply_present_i && !power_off_state_i) begin
			unique case (sequence_slot_code)
				LECR_SEQ_NEVER: begin
					next_enable = 1'b0;
				end
				LECR_SEQ_ALWAYS: begin
					next_enable = 1'b1;
				end
				LECR_SEQ_AT_0: begin
					next_enable = phase_0;
				end
				LECR_SEQ_AT_25: begin
					next_enable = phase_25;
				end
				LECR_SEQ_AT_50: begin
					next_enable = phase_50;
				end
				LECR_SEQ_OFF_A, LECR_SEQ_OFF_B: begin
					next_enable = 1'b0;
				end
				LECR_SEQ_SOFTWARE: begin
					if (phase_100) begin
						unique case (software_enable_select)
							LECR_SEL_OFF: begin
								next_enable = 1'b0;
							end
							LECR_SEL_ON: begin
								next_enable = 1'b1;
							end
							LECR_SEL_FIRST: begin
								next_enable = multipurpose_input_first_i;
							end
							LECR_SEL_SECOND: begin
								next_enable = multipurpose_input_second_i;
							end
						endcase
					end
				end
			endcase
		end
	end

	// hard-reset states always discharge; the option adds discharge while disabled
	always_comb begin
		next_discharge = power_off_state_i;
		if (active_discharge_on_disable && !next_enable) begin
			next_discharge = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ldo_enable_o <= 1'b0;
			discharge_o <= 1'b0;
		end else begin
			ldo_enable_o <= next_enable;
			discharge_o <= next_discharge;
		end
	end

	// mode only follows the written bit while the regulator is off
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			load_switch_o <= `LECR_MODE_RST;
		end else if (!ldo_enable_o) begin
			load_switch_o <= load_switch_select;
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_comb begin
		next_rd_data = 8'h00;
		if (rd_en_i) begin
			if (hit(addr_i, `LECR_CFG_ADDR)) begin
				next_rd_data[`LECR_SEQ_MSB:`LECR_SEQ_LSB] = sequence_slot_code;
				next_rd_data[`LECR_DSC_BIT] = active_discharge_on_disable;
				next_rd_data[`LECR_SEL_MSB:`LECR_SEL_LSB] = software_enable_select;
				next_rd_data[`LECR_MODE_BIT] = load_switch_select;
			end else if (hit(addr_i, `LECR_VOLT_ADDR)) begin
				next_rd_data[`LECR_VOLT_MSB:0] = output_voltage_code_o;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= `LECR_RD_RST;
		end else begin
			rd_data_o <= next_rd_data;
		end
	end

	// checks
	property p_seq_read_only;
		@(posedge clk_i) disable iff (rst_i)
		(seq_loaded && cfg_wr) |=> $stable(sequence_slot_code);
	endproperty
	a_seq_read_only: assert property (p_seq_read_only) else $error("slot code changed by a write");

	property p_seq_never;
		@(posedge clk_i) disable iff (rst_i)
		(seq_loaded && sequence_slot_code == LECR_SEQ_NEVER) |=> !ldo_enable_o;
	endproperty
	a_seq_never: assert property (p_seq_never) else $error("slot 000 enabled the regulator");

	property p_seq_always;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_ALWAYS && supply_present_i && !power_off_state_i) |=> ldo_enable_o;
	endproperty
	a_seq_always: assert property (p_seq_always) else $error("slot 001 did not enable");

	property p_seq_phase;
		@(posedge clk_i) disable iff (rst_i)
		(supply_present_i && !power_off_state_i && sequence_slot_code == LECR_SEQ_AT_25)
			|=> (ldo_enable_o == $past(phase_25));
	endproperty
	a_seq_phase: assert property (p_seq_phase) else $error("slot 011 enable off the quarter point");

	property p_seq_half;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_AT_50 && !phase_50) |=> !ldo_enable_o;
	endproperty
	a_seq_half: assert property (p_seq_half) else $error("slot 100 enabled before half delay");

	property p_sw_wait_boot;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_SOFTWARE && !phase_100) |=> !ldo_enable_o;
	endproperty
	a_sw_wait_boot: assert property (p_sw_wait_boot) else $error("software control before full delay");

	property p_sel_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code != LECR_SEQ_SOFTWARE && software_enable_select == LECR_SEL_ON
			&& sequence_slot_code != LECR_SEQ_ALWAYS && !phase_0) |=> !ldo_enable_o;
	endproperty
	a_sel_ignored: assert property (p_sel_ignored) else $error("selector acted outside slot 111");

	property p_sel_on;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_SOFTWARE && phase_100 && supply_present_i && !power_off_state_i
			&& software_enable_select == LECR_SEL_ON) |=> ldo_enable_o;
	endproperty
	a_sel_on: assert property (p_sel_on) else $error("selector 01 did not enable");

	property p_sel_first;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_SOFTWARE && phase_100 && supply_present_i && !power_off_state_i
			&& software_enable_select == LECR_SEL_FIRST) |=> (ldo_enable_o == $past(multipurpose_input_first_i));
	endproperty
	a_sel_first: assert property (p_sel_first) else $error("selector 10 not following first input");

	property p_sel_second;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_SOFTWARE && phase_100 && supply_present_i && !power_off_state_i
			&& software_enable_select == LECR_SEL_SECOND) |=> (ldo_enable_o == $past(multipurpose_input_second_i));
	endproperty
	a_sel_second: assert property (p_sel_second) else $error("selector 11 not following second input");

	property p_dsc_on;
		@(posedge clk_i) disable iff (rst_i)
		##1 ($past(active_discharge_on_disable) && !ldo_enable_o) |-> discharge_o;
	endproperty
	a_dsc_on: assert property (p_dsc_on) else $error("no discharge while disabled with option set");

	property p_dsc_off;
		@(posedge clk_i) disable iff (rst_i)
		!active_discharge_on_disable |=> (discharge_o == $past(power_off_state_i));
	endproperty
	a_dsc_off: assert property (p_dsc_off) else $error("discharge outside hard reset with option clear");

	property p_mode_hold;
		@(posedge clk_i) disable iff (rst_i)
		($past(ldo_enable_o) && ldo_enable_o) |-> $stable(load_switch_o);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed while enabled");

	property p_mode_apply;
		@(posedge clk_i) disable iff (rst_i)
		(!ldo_enable_o && !cfg_wr) |=> (load_switch_o == $past(load_switch_select));
	endproperty
	a_mode_apply: assert property (p_mode_apply) else $error("mode not applied while disabled");

	property p_volt_read;
		@(posedge clk_i) disable iff (rst_i)
		(rd_en_i && hit(addr_i, `LECR_VOLT_ADDR)) |=> (rd_data_o == {3'h0, $past(output_voltage_code_o)});
	endproperty
	a_volt_read: assert property (p_volt_read) else $error("voltage readback mismatch");

	property p_cfg_read;
		@(posedge clk_i) disable iff (rst_i)
		(rd_en_i && hit(addr_i, `LECR_CFG_ADDR)) |=> (rd_data_o == {$past(sequence_slot_code), 1'b0,
			$past(active_discharge_on_disable), $past(software_enable_select), $past(load_switch_select)});
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback mismatch");

	property p_seq_off_codes;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_OFF_A || sequence_slot_code == LECR_SEQ_OFF_B) |=> !ldo_enable_o;
	endproperty
	a_seq_off_codes: assert property (p_seq_off_codes) else $error("slot 101 or 110 enabled");

	property p_seq_start;
		@(posedge clk_i) disable iff (rst_i)
		(supply_present_i && !power_off_state_i && sequence_slot_code == LECR_SEQ_AT_0)
			|=> (ldo_enable_o == $past(phase_0));
	endproperty
	a_seq_start: assert property (p_seq_start) else $error("slot 010 enable off the start point");

	property p_seq_half_on;
		@(posedge clk_i) disable iff (rst_i)
		(supply_present_i && !power_off_state_i && sequence_slot_code == LECR_SEQ_AT_50)
			|=> (ldo_enable_o == $past(phase_50));
	endproperty
	a_seq_half_on: assert property (p_seq_half_on) else $error("slot 100 enable off the half point");

	property p_sel_off;
		@(posedge clk_i) disable iff (rst_i)
		(sequence_slot_code == LECR_SEQ_SOFTWARE && software_enable_select == LECR_SEL_OFF) |=> !ldo_enable_o;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("selector 00 left the regulator on");

	property p_hard_off;
		@(posedge clk_i) disable iff (rst_i)
		power_off_state_i |=> (!ldo_enable_o && discharge_o);
	endproperty
	a_hard_off: assert property (p_hard_off) else $error("hard reset state not off and discharging");

	property p_volt_write;
		@(posedge clk_i) disable iff (rst_i)
		volt_wr |=> (output_voltage_code_o == $past(wr_data_i[`LECR_VOLT_MSB:0]));
	endproperty
	a_volt_write: assert property (p_volt_write) else $error("voltage code not taken from write");

	property p_dsc_write;
		@(posedge clk_i) disable iff (rst_i)
		cfg_wr |=> (active_discharge_on_disable == $past(wr_data_i[`LECR_DSC_BIT]));
	endproperty
	a_dsc_write: assert property (p_dsc_write) else $error("discharge option not taken from write");
endmodule

`default_nettype wire

// [src/lecr_defs.svh]
// register offsets, field positions, reset values and timing counts for the regulator-three control bank
// assumes inclusion by bare name from every design file that needs them
`ifndef LECR_DEFS_SVH
`define LECR_DEFS_SVH

`define LECR_CFG_ADDR 8'h16
`define LECR_VOLT_ADDR 8'h17

`define LECR_SEQ_MSB 7
`define LECR_SEQ_LSB 5
`define LECR_RFU_BIT 4
`define LECR_DSC_BIT 3
`define LECR_SEL_MSB 2
`define LECR_SEL_LSB 1
`define LECR_MODE_BIT 0
`define LECR_VOLT_MSB 4

`define LECR_SEQ_RST 3'h0
`define LECR_DSC_RST 1'b0
`define LECR_SEL_RST 2'h0
`define LECR_MODE_RST 1'b0
`define LECR_VOLT_RST 5'h00
`define LECR_RD_RST 8'h00

`define LECR_CLK_PERIOD_NS 50
`define LECR_BOOT_DELAY_NS 1000000
`define LECR_BOOT_DELAY_CYCLES ((`LECR_BOOT_DELAY_NS + `LECR_CLK_PERIOD_NS - 1) / `LECR_CLK_PERIOD_NS)

`endif

// [src/lecr_pkg.sv]
// types shared by the regulator-three control bank
// assumes nothing beyond a SystemVerilog compiler
package lecr_pkg;
	typedef enum logic [1:0] {
		LECR_SEL_OFF = 2'h0,
		LECR_SEL_ON = 2'h1,
		LECR_SEL_FIRST = 2'h2,
		LECR_SEL_SECOND = 2'h3
	} lecr_sel_t;

	typedef enum logic [2:0] {
		LECR_SEQ_NEVER = 3'h0,
		LECR_SEQ_ALWAYS = 3'h1,
		LECR_SEQ_AT_0 = 3'h2,
		LECR_SEQ_AT_25 = 3'h3,
		LECR_SEQ_AT_50 = 3'h4,
		LECR_SEQ_OFF_A = 3'h5,
		LECR_SEQ_OFF_B = 3'h6,
		LECR_SEQ_SOFTWARE = 3'h7
	} lecr_seq_t;

	typedef enum logic [1:0] {
		LECR_BOOT_IDLE = 2'b00,
		LECR_BOOT_RUN = 2'b01,
		LECR_BOOT_DONE = 2'b11
	} lecr_boot_state_t;
endpackage

// [src/lecr_boot_timer.sv]
// boot delay timer: flags reaching 0, 25, 50 and 100 percent of the boot delay
// assumes supply_present_i synchronous to clk_i; losing supply restarts the delay
`timescale 1ns/1ps
`default_nettype none
`include "lecr_defs.svh"

module lecr_boot_timer
	import lecr_pkg::*;
#(
	parameter int DELAY_CYCLES = `LECR_BOOT_DELAY_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// supply
	input wire logic supply_present_i,
	// phase flags
	output logic phase_0_o,
	output logic phase_25_o,
	output logic phase_50_o,
	output logic phase_100_o
);
	localparam int CW = $clog2(DELAY_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);
	localparam logic [CW-1:0] QUARTER = CW'(DELAY_CYCLES / 4);
	localparam logic [CW-1:0] HALF = CW'(DELAY_CYCLES / 2);

	lecr_boot_state_t state;
	logic [CW-1:0] count;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= LECR_BOOT_IDLE;
			count <= '0;
		end else if (!supply_present_i) begin
			state <= LECR_BOOT_IDLE;
			count <= '0;
		end else begin
			unique case (state)
				LECR_BOOT_IDLE: begin
					state <= LECR_BOOT_RUN;
				end
				LECR_BOOT_RUN: begin
					if (count == LAST) begin
						state <= LECR_BOOT_DONE;
					end else begin
						count <= count + 1'b1;
					end
				end
				LECR_BOOT_DONE: begin
					state <= LECR_BOOT_DONE;
				end
				default: begin
					state <= LECR_BOOT_IDLE;
					count <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_0_o <= 1'b0;
			phase_25_o <= 1'b0;
			phase_50_o <= 1'b0;
			phase_100_o <= 1'b0;
		end else begin
			phase_0_o <= supply_present_i && (state != LECR_BOOT_IDLE);
			phase_25_o <= supply_present_i && (state != LECR_BOOT_IDLE) && (count >= QUARTER);
			phase_50_o <= supply_present_i && (state != LECR_BOOT_IDLE) && (count >= HALF);
			phase_100_o <= supply_present_i && (state == LECR_BOOT_DONE);
		end
	end
endmodule

`default_nettype wire

// [verification/test_ldo_enable_control_regs.sv]
// self-checking bench for the regulator-three control bank
// assumes lecr_regs and lecr_boot_timer compiled with lecr_pkg; boot delay shortened to 16 cycles
`timescale 1ns/1ps
`default_nettype none
`include "lecr_defs.svh"

module test_ldo_enable_control_regs;
	localparam int DELAY = 16;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wr_data_i = 8'h00;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic supply_present_i = 1'b1;
	logic power_off_state_i = 1'b0;
	logic [2:0] seq_strap_i = 3'h0;
	logic mp_first = 1'b0;
	logic mp_second = 1'b0;
	logic [7:0] rd_data_o;
	logic ldo_enable_o;
	logic load_switch_o;
	logic discharge_o;
	logic [4:0] output_voltage_code_o;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	logic en_exp;

	lecr_regs #(.BOOT_DELAY_CYCLES(DELAY)) i_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_i(addr_i),
		.wr_data_i(wr_data_i),
		.wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i),
		.rd_data_o(rd_data_o),
		.supply_present_i(supply_present_i),
		.power_off_state_i(power_off_state_i),
		.seq_strap_i(seq_strap_i),
		.multipurpose_input_first_i(mp_first),
		.multipurpose_input_second_i(mp_second),
		.ldo_enable_o(ldo_enable_o),
		.load_switch_o(load_switch_o),
		.discharge_o(discharge_o),
		.output_voltage_code_o(output_voltage_code_o)
	);

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// hang guard, far above the expected run length
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			test_done();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		chk("read data", exp, rd_data_o);
	endtask

	task automatic reset_with(input logic [2:0] code);
		@(posedge clk_i);
		rst_i <= 1'b1;
		seq_strap_i <= code;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	// settle three edges past an input change
	task automatic outs(input logic en, input logic dsc);
		repeat (3) @(posedge clk_i);
		#1;
		chk("enable", {7'h00, en}, {7'h00, ldo_enable_o});
		chk("discharge", {7'h00, dsc}, {7'h00, discharge_o});
	endtask

	initial begin
		// every slot code: boot timing, read-only slot field, selector ignored outside 111
		for (int c = 0; c < 8; c++) begin
			reset_with(c[2:0]);
			wr(`LECR_CFG_ADDR, 8'hf2);
			repeat (5) @(posedge clk_i);
			#1;
			en_exp = (c == 1) || (c == 2);
			if (c != 3) chk("early enable", {7'h00, en_exp}, {7'h00, ldo_enable_o});
			repeat (40) @(posedge clk_i);
			#1;
			en_exp = (c >= 1 && c <= 4) || (c == 7);
			chk("boot enable", {7'h00, en_exp}, {7'h00, ldo_enable_o});
			rd(`LECR_CFG_ADDR, {c[2:0], 5'h02});
			rd(`LECR_VOLT_ADDR, 8'h00);
		end
		$display("test slot codes done");
		// slot 111 with full delay reached: selector, inputs and discharge option
		for (int d = 0; d < 2; d++) begin
			for (int s = 0; s < 4; s++) begin
				for (int m = 0; m < 4; m++) begin
					@(posedge clk_i);
					mp_first <= m[0];
					mp_second <= m[1];
					wr(`LECR_CFG_ADDR, {4'h0, d[0], s[1:0], 1'b0});
					en_exp = (s == 1) || (s == 2 && m[0]) || (s == 3 && m[1]);
					outs(en_exp, d[0] & ~en_exp);
				end
			end
		end
		$display("test selector done");
		wr(`LECR_CFG_ADDR, 8'h02);
		@(posedge clk_i);
		power_off_state_i <= 1'b1;
		outs(1'b0, 1'b1);
		@(posedge clk_i);
		power_off_state_i <= 1'b0;
		outs(1'b1, 1'b0);
		$display("test hard reset done");
		// mode bit applied only while off
		wr(`LECR_CFG_ADDR, 8'h01);
		outs(1'b0, 1'b0);
		chk("mode off", 8'h01, {7'h00, load_switch_o});
		wr(`LECR_CFG_ADDR, 8'h03);
		outs(1'b1, 1'b0);
		chk("mode on", 8'h01, {7'h00, load_switch_o});
		wr(`LECR_CFG_ADDR, 8'h02);
		outs(1'b1, 1'b0);
		chk("mode frozen", 8'h01, {7'h00, load_switch_o});
		// pending mode written while on must land once the regulator goes off without a new write
		@(posedge clk_i);
		power_off_state_i <= 1'b1;
		outs(1'b0, 1'b1);
		chk("mode cleared", 8'h00, {7'h00, load_switch_o});
		@(posedge clk_i);
		power_off_state_i <= 1'b0;
		wr(`LECR_CFG_ADDR, 8'h00);
		outs(1'b0, 1'b0);
		$display("test mode latch done");
		// voltage code, unmapped address, read data standing one cycle
		wr(`LECR_VOLT_ADDR, 8'hff);
		rd(`LECR_VOLT_ADDR, 8'h1f);
		@(posedge clk_i);
		#1;
		chk("read data idle", 8'h00, rd_data_o);
		wr(`LECR_VOLT_ADDR, 8'h0a);
		#1;
		chk("voltage code", 8'h0a, {3'h0, output_voltage_code_o});
		wr(8'h18, 8'h55);
		rd(8'h18, 8'h00);
		rd(`LECR_VOLT_ADDR, 8'h0a);
		$display("test voltage done");
		// supply loss disables even with selector on
		wr(`LECR_CFG_ADDR, 8'h02);
		@(posedge clk_i);
		supply_present_i <= 1'b0;
		outs(1'b0, 1'b0);
		$display("test supply loss done");
		test_done();
	end
endmodule
`default_nettype wire
